// ==== rtl/ccc_top.sv ====
// charge cycle, boost entry and status reporting control
`timescale 1ns/1ps
module ccc_top
  import ccc_pkg::*;
#(
  parameter int P_TICK_CYCLES = TICK_CYCLES,
  parameter int P_INT_CYCLES = INT_PULSE_CYCLES,
  parameter int P_MS_PER_HOUR = MS_PER_HOUR
) (
  input wire logic i_clk,                        // 250 MHz clock
  input wire logic i_rst_n,                      // sync reset, active low
  input wire logic i_host_power_out_enable,      // boost enable bit
  input wire logic i_otg_pin,                    // boost enable pin
  input wire logic i_rate_wr,                    // write strobe, rate bit
  input wire logic i_boost_switch_rate_sel,      // 1: 1.5 MHz
  input wire logic [2:0] i_boost_voltage_field,  // boost voltage
  input wire logic [2:0] i_boost_current_limit_field, // boost limit
  input wire logic i_bat_above_lowv,             // boost entry compare
  input wire logic i_vbus_below_sleep,           // no input source
  input wire logic i_boost_ts_ok,                // boost temp window
  input wire logic i_bat_above_boost_floor,      // boost floor compare
  input wire logic [2:0] i_detected_source_code, // source type found
  input wire logic i_param_wr,                   // parameter write strobe
  input wire logic [12:0] i_vreg_mv,             // charge voltage
  input wire logic [12:0] i_fast_charge_current_field, // fast mA
  input wire logic [12:0] i_precharge_ma,        // precharge mA
  input wire logic [12:0] i_term_ma,             // termination mA
  input wire logic [12:0] i_min_system_voltage_field, // min sys mV
  input wire logic [4:0] i_timer_hours,          // safety timer hours
  input wire logic i_charge_enable_bit,          // charge enable bit
  input wire logic i_charge_enable_pin_n,        // charge enable pin
  input wire logic i_battery_switch_off_bit,     // force switch off
  input wire logic i_recharge_threshold_sel,     // 1: 200 mV below
  input wire logic i_indicator_pin_disable,      // release indicator
  input wire logic i_term_enable,                // termination enable
  input wire logic [6:0] i_resistance_comp_field, // comp milliohm
  input wire logic [12:0] i_comp_voltage_ceiling, // comp ceiling mV
  input wire logic i_warm_voltage_sel,           // 0: drop in warm band
  input wire logic i_cool_current_sel,           // 1: 20 %, 0: 50 %
  input wire logic [2:0] i_thermistor_input,     // thermistor zone
  input wire logic i_converter_on,               // buck converter up
  input wire logic [12:0] i_bat_mv,              // battery voltage
  input wire logic [12:0] i_fast_charge_current_field_actual_ma,      // charge current
  input wire logic i_bat_below_min_sys,          // system held at min
  input wire logic i_sys_below_bat,              // supplement needed
  input wire logic i_iin_over_cap,               // input current limit
  input wire logic i_vin_below_floor,            // input voltage floor
  input wire logic i_thermal_reg,                // thermal regulation
  output logic o_boost_run,                      // boost converter on
  output logic o_boost_rate_1p5m,                // 1: 1.5 MHz rate
  output logic [2:0] o_boost_voltage,            // boost voltage in use
  output logic [2:0] o_boost_ilim,               // boost limit in use
  output logic [2:0] o_input_source_type_code,   // source code
  output logic [12:0] o_min_sys_mv,              // min system target
  output logic o_min_sys_regulation_flag,        // min sys regulation
  output logic o_voltage_limit_active_flag,      // input voltage limit
  output logic o_current_limit_active_flag,      // input current limit
  output logic [12:0] o_fast_charge_current_field_target_ma,          // charge current target
  output logic [12:0] o_vreg_target_mv,          // regulation target
  output logic [1:0] o_charge_phase_code,        // charge phase
  output logic [1:0] o_charge_fault_code,        // charge fault
  output logic o_battery_switch_on,              // battery switch
  output logic o_indicator_out,                  // open drain level
  output logic o_indicator_oe,                   // 1: pull pin low
  output logic o_int                             // host alert pulse
);

  //////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [12:0] ccc_comp_mv(input logic [12:0] ima,
      input logic [6:0] rc, input logic [12:0] ceil_mv);
    logic [19:0] uv;
    logic [19:0] mv;
    uv = ima * rc;
    mv = uv / 20'(UV_PER_MV);
    return (mv > {7'h00, ceil_mv}) ? ceil_mv : mv[12:0];
  endfunction : ccc_comp_mv

  function automatic logic [12:0] ccc_cool_ma(input logic [12:0] ima,
      input logic sel);
    return sel ? ima / COOL_DIV_FIFTH : ima / COOL_DIV_HALF;
  endfunction : ccc_cool_ma

  //////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    ccc_chg_state_t chg;
    logic pre;
    logic half_ph;
    logic [MS_W-1:0] ms_cnt;
    logic [4:0] hr_cnt;
    logic tmr_ev;
    logic term_ev;
    logic en_q;
    logic [5:0] bst_cnt;
    logic [8:0] blink_cnt;
    logic blink;
    logic [12:0] vreg;
    logic [12:0] fast_charge_current_field;
    logic [12:0] ipre;
    logic [12:0] iterm;
    logic [12:0] sysmin;
    logic [4:0] tmr_hours;
    logic bst_run;
    logic rate_1p5;
    logic [2:0] bst_v;
    logic [2:0] bst_i;
    logic [2:0] src;
    logic sys_flag;
    logic vdpm;
    logic idpm;
    logic [12:0] i_tgt;
    logic [12:0] v_tgt;
    logic [1:0] phase;
    logic [1:0] fault;
    logic bsw_on;
    logic ind_oe;
  } ccc_top_st_t;

  ccc_top_st_t st;
  ccc_top_st_t next_st;
  logic tick;
  logic chg_en;
  logic ts_in;
  logic limiting;
  logic suspended;
  logic start_ok;
  logic term_ok;
  logic [12:0] rechg_mv;
  logic [12:0] base_v;

  ccc_tick #(.CYCLES(P_TICK_CYCLES)) u_tick (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .o_tick(tick)
  );

  ccc_pulse #(.CYCLES(P_INT_CYCLES)) u_alert (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_fire(st.term_ev | st.tmr_ev),
    .o_pulse(o_int)
  );

  //////////////////////////////////////////////////////////////////////////
  // charge conditions
  assign chg_en = i_charge_enable_bit & ~i_charge_enable_pin_n;
  assign ts_in = (i_thermistor_input != TS_COLD) &&
                 (i_thermistor_input != TS_HOT);
  assign limiting = i_iin_over_cap | i_vin_below_floor | i_thermal_reg;
  assign suspended = ~ts_in;
  assign start_ok = i_converter_on & chg_en & (st.fast_charge_current_field != '0) & ts_in &
                    (st.fault == FAULT_NONE) &
                    ~i_battery_switch_off_bit;
  assign rechg_mv = st.vreg - (i_recharge_threshold_sel ? RECHG_OFS_HI :
                               RECHG_OFS_LO);
  assign term_ok = (i_fast_charge_current_field_actual_ma < st.iterm) && (i_bat_mv > rechg_mv) &&
                   !limiting && i_term_enable;
  assign base_v = (i_thermistor_input == TS_WARM && !i_warm_voltage_sel) ?
                  st.vreg - WARM_DROP_MV : st.vreg;

  always_comb begin
    next_st = st;
    next_st.term_ev = 1'b0;
    next_st.tmr_ev = 1'b0;
    next_st.en_q = chg_en;
    if (i_param_wr) begin
      next_st.vreg = i_vreg_mv;
      next_st.fast_charge_current_field = i_fast_charge_current_field;
      next_st.ipre = i_precharge_ma;
      next_st.iterm = i_term_ma;
      next_st.sysmin = i_min_system_voltage_field;
      next_st.tmr_hours = i_timer_hours;
    end
    // boost entry delay and rate
    if (!(i_host_power_out_enable & i_otg_pin)) begin
      next_st.bst_cnt = '0;
    end else if (tick && st.bst_cnt != 6'(BOOST_DLY_MS)) begin
      next_st.bst_cnt = st.bst_cnt + 6'h01;
    end
    next_st.bst_run = i_host_power_out_enable & i_otg_pin &
                      (st.bst_cnt == 6'(BOOST_DLY_MS)) &
                      i_bat_above_lowv & i_vbus_below_sleep &
                      i_boost_ts_ok & i_bat_above_boost_floor;
    if (i_rate_wr && !i_host_power_out_enable) begin
      next_st.rate_1p5 = i_boost_switch_rate_sel;
    end
    next_st.bst_v = i_boost_voltage_field;
    next_st.bst_i = i_boost_current_limit_field;
    next_st.src = next_st.bst_run ? SRC_BOOST :
                  i_detected_source_code;
    next_st.sys_flag = i_bat_below_min_sys;
    next_st.vdpm = i_vin_below_floor;
    next_st.idpm = i_iin_over_cap;
    // indicator blink base
    if (tick) begin
      if (st.blink_cnt == 9'(BLINK_HALF_MS - 1)) begin
        next_st.blink_cnt = '0;
        next_st.blink = ~st.blink;
      end else begin
        next_st.blink_cnt = st.blink_cnt + 9'h001;
      end
    end
    if (!chg_en) begin
      next_st.fault = FAULT_NONE;
    end
    // charge cycle
    case (st.chg)
      CCS_IDLE: begin
        if (start_ok && !(i_charge_enable_bit && i_charge_enable_pin_n)) begin
          next_st.chg = CCS_CHARGE;
          next_st.pre = i_bat_mv < BAT_PRE_MV;
          next_st.ms_cnt = '0;
          next_st.hr_cnt = '0;
          next_st.half_ph = 1'b0;
        end
      end
      CCS_CHARGE: begin
        if (!chg_en || i_battery_switch_off_bit) begin
          next_st.chg = CCS_IDLE;
        end else if (!suspended && term_ok) begin
          next_st.chg = CCS_DONE;
          next_st.term_ev = 1'b1;
        end else if (!suspended) begin
          if (i_bat_mv >= BAT_PRE_MV) begin
            next_st.pre = 1'b0;
          end
          if (tick) begin
            next_st.half_ph = ~st.half_ph;
          end
          if (tick && (!limiting || st.half_ph)) begin
            if (st.ms_cnt == MS_W'(P_MS_PER_HOUR - 1)) begin
              next_st.ms_cnt = '0;
              next_st.hr_cnt = st.hr_cnt + 5'h01;
              if (st.tmr_hours != '0 &&
                  st.hr_cnt + 5'h01 == st.tmr_hours) begin
                next_st.chg = CCS_IDLE;
                next_st.fault = FAULT_TIMER;
                next_st.tmr_ev = 1'b1;
              end
            end else begin
              next_st.ms_cnt = st.ms_cnt + MS_W'(1);
            end
          end
        end
      end
      CCS_DONE: begin
        if (!chg_en) begin
          next_st.chg = CCS_IDLE;
        end else if (i_bat_mv < rechg_mv && start_ok) begin
          next_st.chg = CCS_CHARGE;
          next_st.pre = i_bat_mv < BAT_PRE_MV;
          next_st.ms_cnt = '0;
          next_st.hr_cnt = '0;
        end
      end
      default: next_st.chg = CCS_IDLE;
    endcase
    // reporting and targets
    case (next_st.chg)
      CCS_CHARGE: next_st.phase = next_st.pre ? PHASE_PRE : PHASE_FAST;
      CCS_DONE: next_st.phase = PHASE_DONE;
      default: next_st.phase = PHASE_OFF;
    endcase
    if (next_st.chg != CCS_CHARGE || suspended) begin
      next_st.i_tgt = '0;
    end else if (i_bat_mv < BAT_SHORT_MV) begin
      next_st.i_tgt = '0; // short current from analog side
    end else if (next_st.pre) begin
      next_st.i_tgt = st.ipre;
    end else if (i_thermistor_input == TS_COOL) begin
      next_st.i_tgt = ccc_cool_ma(st.fast_charge_current_field, i_cool_current_sel);
    end else begin
      next_st.i_tgt = st.fast_charge_current_field;
    end
    next_st.v_tgt = base_v + ccc_comp_mv(i_fast_charge_current_field_actual_ma,
        i_resistance_comp_field, i_comp_voltage_ceiling);
    next_st.bsw_on = !i_battery_switch_off_bit &&
                     (next_st.chg != CCS_DONE || i_sys_below_bat);
    if (i_indicator_pin_disable) begin
      next_st.ind_oe = 1'b0;
    end else if (next_st.fault != FAULT_NONE ||
                 (next_st.chg == CCS_CHARGE && suspended)) begin
      next_st.ind_oe = next_st.blink;
    end else begin
      next_st.ind_oe = next_st.chg == CCS_CHARGE;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st <= '0;
      st.vreg <= VREG_RST;
      st.fast_charge_current_field <= FAST_CHARGE_CURRENT_FIELD_RST;
      st.ipre <= IPRE_RST;
      st.iterm <= ITERM_RST;
      st.sysmin <= SYSMIN_RST;
      st.tmr_hours <= TIMER_HR_RST;
      st.bsw_on <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs
  assign o_boost_run = st.bst_run;
  assign o_boost_rate_1p5m = st.rate_1p5;
  assign o_boost_voltage = st.bst_v;
  assign o_boost_ilim = st.bst_i;
  assign o_input_source_type_code = st.src;
  assign o_min_sys_mv = st.sysmin;
  assign o_min_sys_regulation_flag = st.sys_flag;
  assign o_voltage_limit_active_flag = st.vdpm;
  assign o_current_limit_active_flag = st.idpm;
  assign o_fast_charge_current_field_target_ma = st.i_tgt;
  assign o_vreg_target_mv = st.v_tgt;
  assign o_charge_phase_code = st.phase;
  assign o_charge_fault_code = st.fault;
  assign o_battery_switch_on = st.bsw_on;
  assign o_indicator_out = 1'b0;
  assign o_indicator_oe = st.ind_oe;

  //////////////////////////////////////////////////////////////////////////
  // checks
  boost_delay_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(o_boost_run) |-> $past(st.bst_cnt) == 6'(BOOST_DLY_MS))
    else $error("boost started before entry delay");
  rate_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_host_power_out_enable |=> $stable(o_boost_rate_1p5m))
    else $error("boost rate changed while output enabled");
  boost_code_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_boost_run |-> o_input_source_type_code == SRC_BOOST)
    else $error("source code not boost while boosting");
  boost_floor_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !i_bat_above_boost_floor |=> !o_boost_run)
    else $error("boost ran below battery floor");
  start_gate_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st.chg == CCS_IDLE ##1 st.chg == CCS_CHARGE) |-> $past(start_ok))
    else $error("charge cycle started without conditions");
  term_alert_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st.chg == CCS_CHARGE ##1 st.chg == CCS_DONE) |->
    o_charge_phase_code == PHASE_DONE ##2 o_int)
    else $error("termination not reported");
  term_block_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st.chg == CCS_CHARGE && (!i_term_enable || limiting)) |=>
    st.chg != CCS_DONE)
    else $error("terminated while termination blocked");
  timer_fault_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    st.tmr_ev |-> o_charge_fault_code == FAULT_TIMER ##2 o_int)
    else $error("timer expiry not reported");

endmodule : ccc_top

// ==== rtl/ccc_pkg.sv ====
// constants and types shared by the charge cycle controller
package ccc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_NS = 4;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES = TICK_NS / CLK_NS;
  localparam int INT_PULSE_US = 256;
  localparam int INT_PULSE_CYCLES = (INT_PULSE_US * 1000) / CLK_NS;
  localparam int BOOST_DLY_MS = 30;
  localparam int BLINK_HALF_MS = 500;
  localparam int MS_PER_HOUR = 3600000;
  localparam int MS_W = 22;
  localparam int UV_PER_MV = 1000;

  ////////////////////////////////////////////////////////////////////////////
  // reset values of charging parameters
  localparam logic [12:0] VREG_RST = 13'h1070;
  localparam logic [12:0] FAST_CHARGE_CURRENT_FIELD_RST = 13'h0800;
  localparam logic [12:0] IPRE_RST = 13'h0080;
  localparam logic [12:0] ITERM_RST = 13'h0100;
  localparam logic [12:0] SYSMIN_RST = 13'h0DAC;
  localparam logic [4:0] TIMER_HR_RST = 5'h0C;

  ////////////////////////////////////////////////////////////////////////////
  // thresholds and derating
  localparam logic [12:0] BAT_SHORT_MV = 13'h07D0;
  localparam logic [12:0] BAT_PRE_MV = 13'h0BB8;
  localparam logic [12:0] WARM_DROP_MV = 13'h00C8;
  localparam logic [12:0] RECHG_OFS_LO = 13'h0064;
  localparam logic [12:0] RECHG_OFS_HI = 13'h00C8;
  localparam logic [12:0] COOL_DIV_HALF = 13'h0002;
  localparam logic [12:0] COOL_DIV_FIFTH = 13'h0005;

  ////////////////////////////////////////////////////////////////////////////
  // codes
  localparam logic [2:0] SRC_BOOST = 3'h7;
  localparam logic [1:0] PHASE_OFF = 2'h0;
  localparam logic [1:0] PHASE_PRE = 2'h1;
  localparam logic [1:0] PHASE_FAST = 2'h2;
  localparam logic [1:0] PHASE_DONE = 2'h3;
  localparam logic [1:0] FAULT_NONE = 2'h0;
  localparam logic [1:0] FAULT_TIMER = 2'h3;
  localparam logic [2:0] TS_COLD = 3'h0;
  localparam logic [2:0] TS_COOL = 3'h1;
  localparam logic [2:0] TS_NORMAL = 3'h2;
  localparam logic [2:0] TS_WARM = 3'h3;
  localparam logic [2:0] TS_HOT = 3'h4;

  typedef enum logic [1:0] {CCS_IDLE, CCS_CHARGE, CCS_DONE} ccc_chg_state_t;

endpackage : ccc_pkg

// ==== rtl/ccc_tick.sv ====
// free running divider giving a one-cycle enable per period
`timescale 1ns/1ps
module ccc_tick
  import ccc_pkg::*;
#(
  parameter int CYCLES = TICK_CYCLES
) (
  input wire logic i_clk,   // system clock
  input wire logic i_rst_n, // sync reset, active low
  output logic o_tick       // one-cycle enable
);
  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } ccc_tick_st_t;

  ccc_tick_st_t st;
  ccc_tick_st_t next_st;

  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.cnt == 32'(CYCLES - 1)) begin
      next_st.cnt = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 32'h00000001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_tick = st.tick;
endmodule : ccc_tick

// ==== rtl/ccc_pulse.sv ====
// fixed width one-shot for the host alert line
`timescale 1ns/1ps
module ccc_pulse
  import ccc_pkg::*;
#(
  parameter int CYCLES = INT_PULSE_CYCLES
) (
  input wire logic i_clk,   // system clock
  input wire logic i_rst_n, // sync reset, active low
  input wire logic i_fire,  // event pulse
  output logic o_pulse      // alert level, CYCLES long
);
  typedef struct packed {
    logic [31:0] cnt;
    logic busy;
  } ccc_pulse_st_t;

  ccc_pulse_st_t st;
  ccc_pulse_st_t next_st;

  // events during a running pulse merge into it
  always_comb begin
    next_st = st;
    if (!st.busy) begin
      if (i_fire) begin
        next_st.busy = 1'b1;
        next_st.cnt = '0;
      end
    end else if (st.cnt == 32'(CYCLES - 1)) begin
      next_st.busy = 1'b0;
    end else begin
      next_st.cnt = st.cnt + 32'h00000001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_pulse = st.busy;
endmodule : ccc_pulse

// ==== test/ccc_host_model.sv ====
// host side model: parameter, rate and compensation writes
`timescale 1ns/1ps
module ccc_host_model
  import ccc_pkg::*;
(
  input wire logic i_clk,                   // system clock
  output logic i_param_wr,                  // parameter strobe
  output logic [12:0] i_vreg_mv,            // charge voltage
  output logic [12:0] i_fast_charge_current_field, // fast mA
  output logic [12:0] i_precharge_ma,       // precharge mA
  output logic [12:0] i_term_ma,            // termination mA
  output logic [12:0] i_min_system_voltage_field, // min sys mV
  output logic [4:0] i_timer_hours,         // safety timer
  output logic i_rate_wr,                   // rate strobe
  output logic i_boost_switch_rate_sel,     // rate data
  output logic i_term_enable,               // termination enable
  output logic [6:0] i_resistance_comp_field, // comp milliohm
  output logic [12:0] i_comp_voltage_ceiling  // comp ceiling mV
);
  initial begin
    {i_param_wr, i_rate_wr, i_boost_switch_rate_sel, i_term_enable} = '0;
    {i_vreg_mv, i_fast_charge_current_field, i_precharge_ma} = '0;
    {i_term_ma, i_min_system_voltage_field, i_timer_hours} = '0;
    i_resistance_comp_field = '0;
    i_comp_voltage_ceiling = '0;
  end
  //////////////////////////////////////////////////////////////////////////
  // one-cycle write of all charging parameters
  task wr_params(input logic [4:0] hrs);
    @(posedge i_clk);
    i_vreg_mv <= VREG_RST;
    i_fast_charge_current_field <= FAST_CHARGE_CURRENT_FIELD_RST;
    i_precharge_ma <= IPRE_RST;
    i_term_ma <= ITERM_RST;
    i_min_system_voltage_field <= SYSMIN_RST;
    i_timer_hours <= hrs;
    i_param_wr <= 1'b1;
    @(posedge i_clk);
    i_param_wr <= 1'b0;
  endtask : wr_params
  task wr_rate(input logic v);
    @(posedge i_clk);
    i_boost_switch_rate_sel <= v;
    i_rate_wr <= 1'b1;
    @(posedge i_clk);
    i_rate_wr <= 1'b0;
  endtask : wr_rate
  // both fields set together so the target stays bounded
  task set_comp(input logic [6:0] r, input logic [12:0] c);
    @(posedge i_clk);
    i_resistance_comp_field <= r;
    i_comp_voltage_ceiling <= c;
  endtask : set_comp
  task set_term(input logic v);
    @(posedge i_clk);
    i_term_enable <= v;
  endtask : set_term
endmodule : ccc_host_model

// ==== test/ccc_top_tb.sv ====
// self-checking bench of the charge cycle controller
`timescale 1ns/1ps
module ccc_top_tb;
  import ccc_pkg::*;
  logic i_clk, i_rst_n, i_host_power_out_enable, i_otg_pin, i_bat_above_lowv;
  logic i_vbus_below_sleep, i_boost_ts_ok, i_bat_above_boost_floor;
  logic i_charge_enable_bit, i_charge_enable_pin_n, i_battery_switch_off_bit;
  logic i_recharge_threshold_sel, i_indicator_pin_disable, i_warm_voltage_sel;
  logic i_cool_current_sel, i_converter_on, i_bat_below_min_sys;
  logic i_sys_below_bat, i_iin_over_cap, i_vin_below_floor, i_thermal_reg;
  logic i_param_wr, i_rate_wr, i_boost_switch_rate_sel, i_term_enable;
  logic [12:0] i_vreg_mv, i_fast_charge_current_field, i_precharge_ma;
  logic [12:0] i_term_ma, i_min_system_voltage_field, i_comp_voltage_ceiling;
  logic [12:0] i_bat_mv, i_fast_charge_current_field_actual_ma, o_min_sys_mv, o_fast_charge_current_field_target_ma;
  logic [12:0] o_vreg_target_mv;
  logic [4:0] i_timer_hours;
  logic [6:0] i_resistance_comp_field;
  logic [2:0] i_boost_voltage_field, i_boost_current_limit_field;
  logic [2:0] i_detected_source_code, i_thermistor_input, o_boost_voltage;
  logic [2:0] o_boost_ilim, o_input_source_type_code;
  logic o_boost_run, o_boost_rate_1p5m, o_min_sys_regulation_flag, o_int;
  logic o_voltage_limit_active_flag, o_current_limit_active_flag;
  logic o_battery_switch_on, o_indicator_out, o_indicator_oe;
  logic [1:0] o_charge_phase_code, o_charge_fault_code;
  int n_mismatch = 0;
  int checks_done = 0;
  int k;
  ccc_top #(.P_TICK_CYCLES(8), .P_INT_CYCLES(4), .P_MS_PER_HOUR(3)) uut (.*);
  ccc_host_model host (.*);
  initial begin
    i_clk = 0;
    forever #2 i_clk = ~i_clk;
  end
  //////////////////////////////////////////////////////////////////////////
  task tally_and_finish;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  task chk(input logic [12:0] g, input logic [12:0] e);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %0t got %0h exp %0h", $time, g, e);
    end
  endtask : chk
  task cy(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : cy
  task bail(input int n);
    if (k >= n) begin
      n_mismatch++;
      $display("CHECK FAILED %0t wait ran out", $time);
      tally_and_finish();
    end
  endtask : bail
  //////////////////////////////////////////////////////////////////////////
  task t_reset;
    cy(1);
    chk(o_min_sys_mv, SYSMIN_RST);
    chk(o_charge_phase_code, PHASE_OFF);
    @(posedge i_clk);
    i_bat_below_min_sys <= 1;
    cy(3);
    chk(o_min_sys_regulation_flag, 1);
  endtask : t_reset
  task t_start;
    @(posedge i_clk);
    i_charge_enable_bit <= 1;
    i_converter_on <= 0;
    i_charge_enable_pin_n <= 0;
    cy(5);
    chk(o_charge_phase_code, PHASE_OFF);
    @(posedge i_clk);
    i_converter_on <= 1;
    i_battery_switch_off_bit <= 1;
    cy(4);
    chk(o_charge_phase_code, PHASE_OFF);
    chk(o_battery_switch_on, 0);
    @(posedge i_clk);
    i_battery_switch_off_bit <= 0;
    cy(4);
    chk(o_charge_phase_code, PHASE_PRE);
    chk(o_fast_charge_current_field_target_ma, IPRE_RST);
    chk(o_indicator_oe, 1);
    @(posedge i_clk);
    i_indicator_pin_disable <= 1;
    cy(2);
    chk(o_indicator_oe, 0);
    chk(o_indicator_out, 0);
    @(posedge i_clk);
    i_indicator_pin_disable <= 0;
    i_bat_mv <= 13'h0ED8;
    cy(4);
    chk(o_charge_phase_code, PHASE_FAST);
    chk(o_fast_charge_current_field_target_ma, FAST_CHARGE_CURRENT_FIELD_RST);
    host.set_comp(7'h64, 13'h0032);
    cy(4);
    chk(o_vreg_target_mv, 13'h10A2);
  endtask : t_start
  task t_term;
    host.wr_params(5'h00);
    @(posedge i_clk);
    i_fast_charge_current_field_actual_ma <= 13'h0064;
    i_bat_mv <= 13'h1068;
    cy(10);
    chk(o_charge_phase_code, PHASE_FAST);
    @(posedge i_clk);
    i_iin_over_cap <= 1;
    host.set_term(1);
    cy(10);
    chk(o_charge_phase_code, PHASE_FAST);
    chk(o_current_limit_active_flag, 1);
    @(posedge i_clk);
    {i_iin_over_cap, i_vin_below_floor, i_thermal_reg} <= 3'h3;
    cy(4);
    chk(o_charge_phase_code, PHASE_FAST);
    chk(o_voltage_limit_active_flag, 1);
    chk(o_current_limit_active_flag, 0);
    @(posedge i_clk);
    i_vin_below_floor <= 0;
    cy(4);
    chk(o_charge_phase_code, PHASE_FAST);
    @(posedge i_clk);
    i_thermal_reg <= 0;
    for (k = 0; k < 10 && o_charge_phase_code !== PHASE_DONE; k++) cy(1);
    bail(10);
    chk(o_charge_phase_code, PHASE_DONE);
    for (k = 0; k < 6 && o_int !== 1'b1; k++) cy(1);
    bail(6);
    for (k = 0; k < 20 && o_int === 1'b1; k++) cy(1);
    chk(13'(k), 13'h0004);
    chk(o_battery_switch_on, 0);
    chk(o_indicator_oe, 0);
    @(posedge i_clk);
    i_sys_below_bat <= 1;
    cy(2);
    chk(o_battery_switch_on, 1);
    @(posedge i_clk);
    i_sys_below_bat <= 0;
    i_recharge_threshold_sel <= 1;
    i_bat_mv <= 13'h0FD2;
    cy(4);
    chk(o_charge_phase_code, PHASE_DONE);
    @(posedge i_clk);
    i_bat_mv <= 13'h0FA0;
    for (k = 0; k < 10 && o_charge_phase_code !== PHASE_FAST; k++) cy(1);
    bail(10);
  endtask : t_term
  task t_therm;
    @(posedge i_clk);
    i_thermistor_input <= TS_COLD;
    cy(4);
    chk(o_fast_charge_current_field_target_ma, 13'h0000);
    @(posedge i_clk);
    i_thermistor_input <= TS_COOL;
    i_cool_current_sel <= 1;
    cy(4);
    chk(o_fast_charge_current_field_target_ma, 13'h0199);
    @(posedge i_clk);
    i_thermistor_input <= TS_WARM;
    cy(4);
    chk(o_vreg_target_mv, 13'h0FB2);
    @(posedge i_clk);
    i_warm_voltage_sel <= 1;
    cy(4);
    chk(o_vreg_target_mv, 13'h107A);
    @(posedge i_clk);
    i_thermistor_input <= TS_NORMAL;
    i_charge_enable_bit <= 0;
    host.wr_params(5'h01);
    i_charge_enable_bit <= 1;
    for (k = 0; k < 300 && o_charge_fault_code !== FAULT_TIMER; k++) cy(1);
    bail(300);
    @(posedge i_clk);
    i_charge_enable_bit <= 0;
  endtask : t_therm
  task t_boost;
    host.wr_rate(1);
    cy(2);
    chk(o_boost_rate_1p5m, 1);
    @(posedge i_clk);
    i_host_power_out_enable <= 1;
    i_otg_pin <= 1;
    host.wr_rate(0);
    cy(200);
    chk(o_boost_rate_1p5m, 1);
    chk(o_boost_run, 0);
    for (k = 0; k < 100 && o_boost_run !== 1'b1; k++) cy(1);
    bail(100);
    chk(o_input_source_type_code, SRC_BOOST);
    chk(o_boost_voltage, 3'h5);
    chk(o_boost_ilim, 3'h2);
    @(posedge i_clk);
    i_boost_ts_ok <= 0;
    cy(3);
    chk(o_boost_run, 0);
    chk(o_input_source_type_code, 3'h1);
    @(posedge i_clk);
    i_boost_ts_ok <= 1;
    cy(3);
    chk(o_boost_run, 1);
    @(posedge i_clk);
    i_bat_above_boost_floor <= 0;
    cy(3);
    chk(o_boost_run, 0);
  endtask : t_boost
  initial begin
    i_rst_n = 0;
    {i_host_power_out_enable, i_otg_pin, i_charge_enable_bit} = '0;
    {i_battery_switch_off_bit, i_recharge_threshold_sel} = '0;
    {i_indicator_pin_disable, i_warm_voltage_sel, i_cool_current_sel} = '0;
    {i_bat_below_min_sys, i_sys_below_bat, i_iin_over_cap} = '0;
    {i_vin_below_floor, i_thermal_reg} = '0;
    {i_bat_above_lowv, i_vbus_below_sleep, i_boost_ts_ok} = '1;
    {i_bat_above_boost_floor, i_converter_on} = '1;
    i_charge_enable_pin_n = 1;
    i_boost_voltage_field = 3'h5;
    i_boost_current_limit_field = 3'h2;
    i_detected_source_code = 3'h1;
    i_thermistor_input = TS_NORMAL;
    i_bat_mv = 13'h09C4;
    i_fast_charge_current_field_actual_ma = 13'h07D0;
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1;
    t_reset();
    t_start();
    t_term();
    t_therm();
    t_boost();
    tally_and_finish();
  end
endmodule : ccc_top_tb
